// File: rtl/ccp_pkg.sv
// constants and types for the codec clock and power control registers
package ccp_pkg;

	// register indices; byte address on the bus is four times the index
	localparam logic [5:0] CCP_IDX_HP_PWR   = 6'h0e;
	localparam logic [5:0] CCP_IDX_LINE_PWR = 6'h0f;
	localparam logic [5:0] CCP_IDX_CONV_PWR = 6'h12;
	localparam logic [5:0] CCP_IDX_TO_SCALE = 6'h14;
	localparam logic [5:0] CCP_IDX_RATIO    = 6'h15;
	localparam logic [5:0] CCP_IDX_CLK_SRC  = 6'h16;
	localparam int         CCP_NUM_REGS     = 6;

	// field positions
	localparam int CCP_POS_LEFT      = 1;
	localparam int CCP_POS_RIGHT     = 0;
	localparam int CCP_POS_DAC_LEFT  = 3;
	localparam int CCP_POS_DAC_RIGHT = 2;
	localparam int CCP_POS_ADC_LEFT  = 1;
	localparam int CCP_POS_ADC_RIGHT = 0;
	localparam int CCP_POS_DIV16     = 14;
	localparam int CCP_POS_X4        = 13;
	localparam int CCP_POS_MST_DIV   = 0;
	localparam int CCP_POS_RATIO_LO  = 10;
	localparam int CCP_POS_RATE_LO   = 0;
	localparam int CCP_POS_MST_INV   = 15;
	localparam int CCP_POS_SRC       = 14;
	localparam int CCP_POS_HALF_BYP  = 12;
	localparam int CCP_POS_PIN_CLK   = 3;
	localparam int CCP_POS_CORE_GATE = 2;
	localparam int CCP_POS_DSP_GATE  = 1;
	localparam int CCP_POS_TO_ENA    = 0;

	// reset values of the multi-bit fields
	localparam logic [3:0] CCP_RST_RATIO = 4'h3;
	localparam logic [2:0] CCP_RST_RATE  = 3'h5;

	// core clock to sample rate ratios, indexed by code
	localparam logic [3:0]        CCP_RATIO_LAST = 4'h9;
	localparam logic [9:0][10:0]  CCP_RATIO_TBL  = {
		11'h600, 11'h580, 11'h400, 11'h300, 11'h200,
		11'h180, 11'h100, 11'h0c0, 11'h080, 11'h040};
	localparam logic [2:0] CCP_RATE_LAST = 3'h5;

	// timeout clock scaling factors
	localparam logic [5:0] CCP_TO_DIV_ONE     = 6'h01;
	localparam logic [5:0] CCP_TO_DIV_SIXTEEN = 6'h10;
	localparam logic [2:0] CCP_TO_MUL_ONE     = 3'h1;
	localparam logic [2:0] CCP_TO_MUL_FOUR    = 3'h4;

	typedef struct packed {
		logic       left_headphone_enable;
		logic       right_headphone_enable;
		logic       left_line_out_enable;
		logic       right_line_out_enable;
		logic       left_dac_power;
		logic       right_dac_power;
		logic       left_adc_power;
		logic       right_adc_power;
		logic       timeout_div_sixteen;
		logic       timeout_mult_four;
		logic       core_clock_div_two;
		logic [3:0] core_to_fs_ratio;
		logic [2:0] sample_rate;
		logic       master_clock_invert;
		logic       core_clock_source;
		logic       timeout_half_bypass;
		logic       pin_clock_out_enable;
		logic       core_clock_gate;
		logic       dsp_clock_gate;
		logic       timeout_clock_enable;
	} ccp_ctrl_t;

	typedef struct packed {
		logic [10:0] ratio_value;
		logic        ratio_valid;
		logic        rate_valid;
		logic [5:0]  timeout_divisor;
		logic [2:0]  timeout_multiplier;
	} ccp_derived_t;

endpackage

// File: rtl/ccp_regs.sv
// codec clock and power control registers behind an apb slave
// Summary of operation
// - Left and right headphone drivers are enabled by bits 1 and 0 of the headphone register, reset off.
// - Left and right line outputs are enabled by bits 1 and 0 of the line-output register, reset off.
// - Left and right DACs are enabled by bits 3 and 2 of the converter register, reset off.
// - Left and right ADCs are enabled by bits 1 and 0 of the converter register, reset off.
// - Clock-source bit 14 picks master clock or locked loop, and scaling bit 0 halves the master clock.
// - Scaling bit 14 divides the timeout clock by 16 and scaling bit 13 multiplies it by 4.
// - Clock-source bit 12 at 0 halves the timeout clock and at 1 passes it through, reset 0.
// - Bits 13:10 of the ratio register select a core to sample rate ratio of 64 to 1536, reset 0011.
// - Bits 2:0 of the ratio register select the sample rate, reset 101, with 110 and 111 reserved.
// - Clock-source bit 15 inverts the master clock, reset off.
// - Clock-source bit 3 enables the clock output on the general-purpose pin, reset off.
// - Clock-source bit 0 enables the zero-cross timeout clock, reset off.
`timescale 1ns/1ps
`default_nettype none

module ccp_regs (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr,
	output ccp_pkg::ccp_ctrl_t         ctrl,
	output ccp_pkg::ccp_derived_t      derived
);

	ccp_pkg::ccp_ctrl_t    ctrl_ff;
	ccp_pkg::ccp_derived_t derived_ff;
	ccp_pkg::ccp_derived_t nxt_derived;
	logic                  pready_ff;
	logic [31:0]           prdata_ff;
	logic [31:0]           nxt_prdata;
	logic                  pslverr_ff;
	logic [5:0]            idx;
	logic                  aligned;
	logic                  hit_hp;
	logic                  hit_line;
	logic                  hit_conv;
	logic                  hit_scale;
	logic                  hit_ratio;
	logic                  hit_src;
	logic                  mapped;
	logic                  done;
	logic                  wr;

	assign idx       = paddr[7:2];
	assign aligned   = (paddr[1:0] == 2'h0);
	assign hit_hp    = aligned && (idx == ccp_pkg::CCP_IDX_HP_PWR);
	assign hit_line  = aligned && (idx == ccp_pkg::CCP_IDX_LINE_PWR);
	assign hit_conv  = aligned && (idx == ccp_pkg::CCP_IDX_CONV_PWR);
	assign hit_scale = aligned && (idx == ccp_pkg::CCP_IDX_TO_SCALE);
	assign hit_ratio = aligned && (idx == ccp_pkg::CCP_IDX_RATIO);
	assign hit_src   = aligned && (idx == ccp_pkg::CCP_IDX_CLK_SRC);
	assign mapped    = hit_hp | hit_line | hit_conv | hit_scale | hit_ratio | hit_src;
	// pready is registered, so every transfer takes one wait state
	assign done      = psel && penable && pready_ff;
	assign wr        = done && pwrite;

	// bus handshake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= psel && penable && !pready_ff;
			pslverr_ff <= psel && penable && !pready_ff && !mapped;
			prdata_ff  <= (psel && penable && !pready_ff && !pwrite) ? nxt_prdata : 32'h0000_0000;
		end
	end

	// read mux; unmapped addresses and reserved bits read zero
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		if (hit_hp) begin
			nxt_prdata[ccp_pkg::CCP_POS_LEFT]  = ctrl_ff.left_headphone_enable;
			nxt_prdata[ccp_pkg::CCP_POS_RIGHT] = ctrl_ff.right_headphone_enable;
		end
		if (hit_line) begin
			nxt_prdata[ccp_pkg::CCP_POS_LEFT]  = ctrl_ff.left_line_out_enable;
			nxt_prdata[ccp_pkg::CCP_POS_RIGHT] = ctrl_ff.right_line_out_enable;
		end
		if (hit_conv) begin
			nxt_prdata[ccp_pkg::CCP_POS_DAC_LEFT]  = ctrl_ff.left_dac_power;
			nxt_prdata[ccp_pkg::CCP_POS_DAC_RIGHT] = ctrl_ff.right_dac_power;
			nxt_prdata[ccp_pkg::CCP_POS_ADC_LEFT]  = ctrl_ff.left_adc_power;
			nxt_prdata[ccp_pkg::CCP_POS_ADC_RIGHT] = ctrl_ff.right_adc_power;
		end
		if (hit_scale) begin
			nxt_prdata[ccp_pkg::CCP_POS_DIV16]    = ctrl_ff.timeout_div_sixteen;
			nxt_prdata[ccp_pkg::CCP_POS_X4]       = ctrl_ff.timeout_mult_four;
			nxt_prdata[ccp_pkg::CCP_POS_MST_DIV]  = ctrl_ff.core_clock_div_two;
		end
		if (hit_ratio) begin
			nxt_prdata[ccp_pkg::CCP_POS_RATIO_LO +: 4] = ctrl_ff.core_to_fs_ratio;
			nxt_prdata[ccp_pkg::CCP_POS_RATE_LO +: 3]  = ctrl_ff.sample_rate;
		end
		if (hit_src) begin
			nxt_prdata[ccp_pkg::CCP_POS_MST_INV]   = ctrl_ff.master_clock_invert;
			nxt_prdata[ccp_pkg::CCP_POS_SRC]       = ctrl_ff.core_clock_source;
			nxt_prdata[ccp_pkg::CCP_POS_HALF_BYP]  = ctrl_ff.timeout_half_bypass;
			nxt_prdata[ccp_pkg::CCP_POS_PIN_CLK]   = ctrl_ff.pin_clock_out_enable;
			nxt_prdata[ccp_pkg::CCP_POS_CORE_GATE] = ctrl_ff.core_clock_gate;
			nxt_prdata[ccp_pkg::CCP_POS_DSP_GATE]  = ctrl_ff.dsp_clock_gate;
			nxt_prdata[ccp_pkg::CCP_POS_TO_ENA]    = ctrl_ff.timeout_clock_enable;
		end
	end

	// headphone power
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff.left_headphone_enable  <= 1'b0;
			ctrl_ff.right_headphone_enable <= 1'b0;
		end else if (wr && hit_hp) begin
			ctrl_ff.left_headphone_enable  <= pwdata[ccp_pkg::CCP_POS_LEFT];
			ctrl_ff.right_headphone_enable <= pwdata[ccp_pkg::CCP_POS_RIGHT];
		end
	end

	// line output power
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff.left_line_out_enable  <= 1'b0;
			ctrl_ff.right_line_out_enable <= 1'b0;
		end else if (wr && hit_line) begin
			ctrl_ff.left_line_out_enable  <= pwdata[ccp_pkg::CCP_POS_LEFT];
			ctrl_ff.right_line_out_enable <= pwdata[ccp_pkg::CCP_POS_RIGHT];
		end
	end

	// converter power
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff.left_dac_power  <= 1'b0;
			ctrl_ff.right_dac_power <= 1'b0;
			ctrl_ff.left_adc_power  <= 1'b0;
			ctrl_ff.right_adc_power <= 1'b0;
		end else if (wr && hit_conv) begin
			ctrl_ff.left_dac_power  <= pwdata[ccp_pkg::CCP_POS_DAC_LEFT];
			ctrl_ff.right_dac_power <= pwdata[ccp_pkg::CCP_POS_DAC_RIGHT];
			ctrl_ff.left_adc_power  <= pwdata[ccp_pkg::CCP_POS_ADC_LEFT];
			ctrl_ff.right_adc_power <= pwdata[ccp_pkg::CCP_POS_ADC_RIGHT];
		end
	end

	// timeout scaling and master clock halving
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff.timeout_div_sixteen <= 1'b0;
			ctrl_ff.timeout_mult_four   <= 1'b0;
			ctrl_ff.core_clock_div_two  <= 1'b0;
		end else if (wr && hit_scale) begin
			ctrl_ff.timeout_div_sixteen <= pwdata[ccp_pkg::CCP_POS_DIV16];
			ctrl_ff.timeout_mult_four   <= pwdata[ccp_pkg::CCP_POS_X4];
			ctrl_ff.core_clock_div_two  <= pwdata[ccp_pkg::CCP_POS_MST_DIV];
		end
	end

	// ratio and sample rate; reserved codes are stored and flagged, not refused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff.core_to_fs_ratio <= ccp_pkg::CCP_RST_RATIO;
			ctrl_ff.sample_rate      <= ccp_pkg::CCP_RST_RATE;
		end else if (wr && hit_ratio) begin
			ctrl_ff.core_to_fs_ratio <= pwdata[ccp_pkg::CCP_POS_RATIO_LO +: 4];
			ctrl_ff.sample_rate      <= pwdata[ccp_pkg::CCP_POS_RATE_LO +: 3];
		end
	end

	// clock source, inversion and gates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff.master_clock_invert  <= 1'b0;
			ctrl_ff.core_clock_source    <= 1'b0;
			ctrl_ff.timeout_half_bypass  <= 1'b0;
			ctrl_ff.pin_clock_out_enable <= 1'b0;
			ctrl_ff.core_clock_gate      <= 1'b0;
			ctrl_ff.dsp_clock_gate       <= 1'b0;
			ctrl_ff.timeout_clock_enable <= 1'b0;
		end else if (wr && hit_src) begin
			ctrl_ff.master_clock_invert  <= pwdata[ccp_pkg::CCP_POS_MST_INV];
			ctrl_ff.core_clock_source    <= pwdata[ccp_pkg::CCP_POS_SRC];
			ctrl_ff.timeout_half_bypass  <= pwdata[ccp_pkg::CCP_POS_HALF_BYP];
			ctrl_ff.pin_clock_out_enable <= pwdata[ccp_pkg::CCP_POS_PIN_CLK];
			ctrl_ff.core_clock_gate      <= pwdata[ccp_pkg::CCP_POS_CORE_GATE];
			ctrl_ff.dsp_clock_gate       <= pwdata[ccp_pkg::CCP_POS_DSP_GATE];
			ctrl_ff.timeout_clock_enable <= pwdata[ccp_pkg::CCP_POS_TO_ENA];
		end
	end

	// decoded clocking figures, one cycle behind the register fields
	always_comb begin
		nxt_derived             = '0;
		nxt_derived.ratio_valid = (ctrl_ff.core_to_fs_ratio <= ccp_pkg::CCP_RATIO_LAST);
		if (nxt_derived.ratio_valid) begin
			nxt_derived.ratio_value = ccp_pkg::CCP_RATIO_TBL[ctrl_ff.core_to_fs_ratio];
		end
		nxt_derived.rate_valid = (ctrl_ff.sample_rate <= ccp_pkg::CCP_RATE_LAST);
		// divide by 16 and by 2 stack; a disabled timeout clock reports zero
		if (ctrl_ff.timeout_clock_enable) begin
			nxt_derived.timeout_divisor = (ctrl_ff.timeout_div_sixteen ?
				ccp_pkg::CCP_TO_DIV_SIXTEEN : ccp_pkg::CCP_TO_DIV_ONE) <<
				(ctrl_ff.timeout_half_bypass ? 1'b0 : 1'b1);
			nxt_derived.timeout_multiplier = ctrl_ff.timeout_mult_four ?
				ccp_pkg::CCP_TO_MUL_FOUR : ccp_pkg::CCP_TO_MUL_ONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			derived_ff <= '0;
		end else begin
			derived_ff <= nxt_derived;
		end
	end

	assign pready  = pready_ff;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;
	assign ctrl    = ctrl_ff;
	assign derived = derived_ff;

	// helper state for the checks below
	logic        wr_q_ff;
	logic [5:0]  idx_q_ff;
	logic [31:0] wdata_q_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_q_ff    <= 1'b0;
			idx_q_ff   <= 6'h00;
			wdata_q_ff <= 32'h0000_0000;
		end else begin
			wr_q_ff    <= wr && aligned;
			idx_q_ff   <= idx;
			wdata_q_ff <= pwdata;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	hp_write_a: assert property (
		wr_q_ff && idx_q_ff == ccp_pkg::CCP_IDX_HP_PWR |->
		ctrl_ff.left_headphone_enable == wdata_q_ff[ccp_pkg::CCP_POS_LEFT] &&
		ctrl_ff.right_headphone_enable == wdata_q_ff[ccp_pkg::CCP_POS_RIGHT])
		else $error("headphone enables do not follow write");

	line_write_a: assert property (
		wr_q_ff && idx_q_ff == ccp_pkg::CCP_IDX_LINE_PWR |->
		ctrl_ff.left_line_out_enable == wdata_q_ff[ccp_pkg::CCP_POS_LEFT] &&
		ctrl_ff.right_line_out_enable == wdata_q_ff[ccp_pkg::CCP_POS_RIGHT])
		else $error("line output enables do not follow write");

	dac_write_a: assert property (
		wr_q_ff && idx_q_ff == ccp_pkg::CCP_IDX_CONV_PWR |->
		ctrl_ff.left_dac_power == wdata_q_ff[ccp_pkg::CCP_POS_DAC_LEFT] &&
		ctrl_ff.right_dac_power == wdata_q_ff[ccp_pkg::CCP_POS_DAC_RIGHT])
		else $error("dac enables do not follow write");

	adc_write_a: assert property (
		wr_q_ff && idx_q_ff == ccp_pkg::CCP_IDX_CONV_PWR |->
		ctrl_ff.left_adc_power == wdata_q_ff[ccp_pkg::CCP_POS_ADC_LEFT] &&
		ctrl_ff.right_adc_power == wdata_q_ff[ccp_pkg::CCP_POS_ADC_RIGHT])
		else $error("adc enables do not follow write");

	core_source_a: assert property (
		wr_q_ff && idx_q_ff == ccp_pkg::CCP_IDX_CLK_SRC |->
		ctrl_ff.core_clock_source == wdata_q_ff[ccp_pkg::CCP_POS_SRC])
		else $error("core clock source does not follow write");

	timeout_scale_a: assert property (
		ctrl_ff.timeout_clock_enable && ctrl_ff.timeout_div_sixteen &&
		ctrl_ff.timeout_half_bypass && ctrl_ff.timeout_mult_four |=>
		derived_ff.timeout_divisor == 6'h10 && derived_ff.timeout_multiplier == 3'h4)
		else $error("timeout scaling wrong");

	timeout_half_a: assert property (
		ctrl_ff.timeout_clock_enable && !ctrl_ff.timeout_div_sixteen &&
		!ctrl_ff.timeout_half_bypass |=> derived_ff.timeout_divisor == 6'h02)
		else $error("timeout clock not halved");

	ratio_decode_a: assert property (
		ctrl_ff.core_to_fs_ratio == 4'h9 |=> derived_ff.ratio_valid &&
		derived_ff.ratio_value == 11'h600)
		else $error("ratio code 1001 not decoded to 1536");

	rate_reserved_a: assert property (
		ctrl_ff.sample_rate[2:1] == 2'h3 |=> !derived_ff.rate_valid)
		else $error("reserved sample rate flagged valid");

	invert_write_a: assert property (
		wr_q_ff && idx_q_ff == ccp_pkg::CCP_IDX_CLK_SRC |->
		ctrl_ff.master_clock_invert == wdata_q_ff[ccp_pkg::CCP_POS_MST_INV] &&
		ctrl_ff.pin_clock_out_enable == wdata_q_ff[ccp_pkg::CCP_POS_PIN_CLK])
		else $error("invert or pin clock does not follow write");

	timeout_off_a: assert property (
		!ctrl_ff.timeout_clock_enable |=> derived_ff.timeout_divisor == 6'h00 &&
		derived_ff.timeout_multiplier == 3'h0)
		else $error("timeout clock reported while disabled");

	gate_hold_a: assert property (
		!(wr && hit_src) |=> $stable(ctrl_ff.core_clock_gate) && $stable(ctrl_ff.dsp_clock_gate))
		else $error("clock gates changed without a write");

	ready_pulse_a: assert property (
		psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
		else $error("pready not a one-cycle answer");

endmodule

`default_nettype wire

// File: verif/ccp_host.sv
// host model: apb master that programs the codec control registers
`timescale 1ns/1ps
`default_nettype none

module ccp_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end

	// entered just after a rising edge; hold keeps the bus for a transfer that follows at once
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic hold, output logic [31:0] rd, output logic err);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= we;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		if (!hold) begin
			psel    <= 1'b0;
			penable <= 1'b0;
			// released lines show junk so a stale value cannot pass for a live one
			paddr   <= ~a;
			pwdata  <= ~d;
			@(posedge pclk);
		end
	endtask
endmodule

`default_nettype wire

// File: verif/codec_clock_power_regs_tb.sv
// self-checking bench for the codec clock and power control registers
`timescale 1ns/1ps
`default_nettype none

module codec_clock_power_regs_tb;
	localparam int LIMIT = 5000;
	localparam logic [5:0] IDX [6] = '{ccp_pkg::CCP_IDX_HP_PWR, ccp_pkg::CCP_IDX_LINE_PWR,
		ccp_pkg::CCP_IDX_CONV_PWR, ccp_pkg::CCP_IDX_TO_SCALE, ccp_pkg::CCP_IDX_RATIO,
		ccp_pkg::CCP_IDX_CLK_SRC};
	localparam logic [15:0] MASK [6] = '{16'h0003, 16'h0003, 16'h000f, 16'h6001, 16'h3c07, 16'hd00f};
	localparam logic [15:0] RSTV [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0c05, 16'h0000};
	localparam logic [15:0] PAT [4]  = '{16'haaaa, 16'h5555, 16'hffff, 16'h0000};
	localparam logic [7:0]  BAD [4]  = '{8'h40, 8'h39, 8'h5a, 8'hfc};
	localparam int RT [10] = '{64, 128, 192, 256, 384, 512, 768, 1024, 1408, 1536};

	logic                  pclk;
	logic                  presetn;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [7:0]            paddr;
	logic [31:0]           pwdata;
	logic                  pready;
	logic [31:0]           prdata;
	logic                  pslverr;
	ccp_pkg::ccp_ctrl_t    ctrl;
	ccp_pkg::ccp_derived_t derived;
	logic [15:0]           sh [6];
	logic [31:0]           rd;
	logic                  err;
	int                    n_fail;
	int                    tests_run;
	int                    cyc;

	ccp_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .ctrl(ctrl), .derived(derived));

	ccp_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

	always #10 pclk = ~pclk;

	task automatic tally_and_finish();
		if (n_fail == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc >= LIMIT) begin
			n_fail++;
			tally_and_finish();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic ccp_pkg::ccp_ctrl_t exp_ctrl();
		return ccp_pkg::ccp_ctrl_t'({sh[0][1:0], sh[1][1:0], sh[2][3:0],
			sh[3][14], sh[3][13], sh[3][0], sh[4][13:10], sh[4][2:0],
			sh[5][15], sh[5][14], sh[5][12], sh[5][3:0]});
	endfunction

	task automatic do_reset();
		presetn <= 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (sh[i]) sh[i] = RSTV[i];
	endtask

	// upper half set on purpose: it must be dropped
	task automatic wr(input int i, input logic [15:0] d);
		i_host.xfer(1'b1, {IDX[i], 2'b00}, {16'hffff, d}, 1'b0, rd, err);
		sh[i] = d & MASK[i];
		check("write error", 32'(err), 32'h0);
	endtask

	task automatic rd_chk(input int i);
		i_host.xfer(1'b0, {IDX[i], 2'b00}, 32'h0, 1'b0, rd, err);
		check("readback", rd, {16'h0000, sh[i]});
		check("read error", 32'(err), 32'h0);
	endtask

	initial begin
		pclk      = 1'b0;
		presetn   = 1'b0;
		n_fail    = 0;
		tests_run = 0;
		cyc       = 0;
		do_reset();
		check("reset ctrl", 32'(ctrl), 32'(exp_ctrl()));
		@(posedge pclk);
		check("reset ratio", 32'(derived.ratio_value), 32'h0000_0100);
		check("reset derived", 32'(derived), 32'({11'h100, 2'b11, 9'h000}));
		for (int i = 0; i < 6; i++) rd_chk(i);
		// each pattern is read back in the very next transfer
		foreach (PAT[p]) for (int i = 0; i < 6; i++) begin
			i_host.xfer(1'b1, {IDX[i], 2'b00}, {16'hffff, PAT[p]}, 1'b1, rd, err);
			sh[i] = PAT[p] & MASK[i];
			check("write error", 32'(err), 32'h0);
			rd_chk(i);
			check("ctrl", 32'(ctrl), 32'(exp_ctrl()));
		end
		for (int c = 0; c < 16; c++) begin
			wr(4, {2'b00, c[3:0], 7'h00, c[2:0]});
			@(posedge pclk);
			check("ratio", 32'(derived.ratio_value), (c < 10) ? RT[c % 10] : 0);
			check("ratio valid", 32'(derived.ratio_valid), 32'(c < 10));
			check("rate valid", 32'(derived.rate_valid), 32'(c[2:0] <= 3'h5));
			rd_chk(4);
		end
		for (int t = 0; t < 16; t++) begin
			wr(3, {1'b0, t[1], t[2], 13'h0000});
			wr(5, {3'b000, t[3], 11'h000, t[0]});
			@(posedge pclk);
			check("timeout div", 32'(derived.timeout_divisor),
				t[0] ? (t[1] ? 16 : 1) * (t[3] ? 1 : 2) : 0);
			check("timeout mul", 32'(derived.timeout_multiplier),
				t[0] ? (t[2] ? 4 : 1) : 0);
			check("ctrl", 32'(ctrl), 32'(exp_ctrl()));
		end
		foreach (BAD[b]) begin
			i_host.xfer(1'b1, BAD[b], 32'hffffffff, 1'b0, rd, err);
			check("bad write error", 32'(err), 32'h1);
			i_host.xfer(1'b0, BAD[b], 32'h0, 1'b0, rd, err);
			check("bad read data", rd, 32'h0);
			check("bad read error", 32'(err), 32'h1);
		end
		check("ctrl after bad", 32'(ctrl), 32'(exp_ctrl()));
		// second reset in mid-run must restore every default
		for (int i = 0; i < 6; i++) wr(i, 16'hffff);
		do_reset();
		check("re-reset ctrl", 32'(ctrl), 32'(exp_ctrl()));
		@(posedge pclk);
		check("re-reset derived", 32'(derived), 32'({11'h100, 2'b11, 9'h000}));
		for (int i = 0; i < 6; i++) rd_chk(i);
		tally_and_finish();
	end
endmodule

`default_nettype wire
